// file: common/dci_pkg.sv
// ==========================================================================
// deserializer configuration image: shared constants
// ==========================================================================
package dci_pkg;

   // image byte and register indices (printed offsets); byte address is four times the index
   localparam logic [3:0] IDX_START_MARKER = 4'h0;
   localparam logic [3:0] IDX_LINK_WAKE    = 4'h1;
   localparam logic [3:0] IDX_PIX_FORMAT   = 4'h2;
   localparam logic [3:0] IDX_ALIGN_FAULT  = 4'h3;
   localparam logic [3:0] IDX_PLL_LOSS     = 4'h4;
   localparam logic [3:0] IDX_SPARE_A      = 4'h5;
   localparam logic [3:0] IDX_SPARE_B      = 4'h6;
   localparam logic [3:0] IDX_END_MARKER   = 4'h7;
   localparam logic [3:0] IDX_STATUS       = 4'h8;
   localparam logic [3:0] IDX_CONTROL      = 4'h9;
   localparam int         IMAGE_BYTES      = 8;

   // marker values
   localparam logic [7:0] START_MARKER_VAL = 8'hBD;
   localparam logic [7:0] END_MARKER_VAL   = 8'h99;

   // field positions
   localparam int BIT_WAKE1        = 1;  // byte 01
   localparam int BIT_DED_UP       = 3;  // byte 01
   localparam int BIT_EMB_UP       = 4;  // byte 01
   localparam int BIT_WAIT_CFG     = 7;  // byte 01
   localparam int BIT_ALIGN_DATA   = 1;  // byte 03
   localparam int BIT_ALIGN_CLK    = 2;  // byte 03
   localparam int BIT_FAULT_TOL    = 3;  // byte 03
   localparam int BIT_PLL_NORESET  = 0;  // byte 04
   localparam int BIT_APPLY        = 0;  // control register

   // status register bit positions
   localparam int ST_IMAGE_VALID   = 0;
   localparam int ST_SETTLING      = 1;
   localparam int ST_RUNNING       = 2;
   localparam int ST_LINK_FAULT    = 3;
   localparam int ST_PLL_LOCKED    = 4;
   localparam int ST_IMAGE_BAD     = 5;

   // pixel data width codes
   localparam logic [1:0] WIDTH_10 = 2'h0;
   localparam logic [1:0] WIDTH_12 = 2'h1;
   localparam logic [1:0] WIDTH_18 = 2'h2;
   localparam logic [1:0] WIDTH_24 = 2'h3;

   // control signal transmit modes
   localparam logic [1:0] CTRL_NEVER  = 2'h0;
   localparam logic [1:0] CTRL_UNUSED = 2'h1;
   localparam logic [1:0] CTRL_EVEN   = 2'h2;
   localparam logic [1:0] CTRL_EVERY  = 2'h3;

   // reset values
   localparam logic [7:0]  BYTE_RST  = 8'h00;
   localparam logic [31:0] WORD_RST  = 32'h0000_0000;

   // settle delay after configuration
   localparam longint CLK_HZ        = 64'd50_000_000;
   localparam longint SETTLE_MS     = 64'd50;
   localparam int     SETTLE_CYCLES = int'((SETTLE_MS * CLK_HZ) / 64'd1000);
   localparam int     SETTLE_W      = 22;

   // loader controller states, gray along idle-load-settle-run
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_LOAD   = 2'b01,
      ST_SETTLE = 2'b11,
      ST_RUN    = 2'b10
   } dci_state_t;

endpackage : dci_pkg

// file: design/dci_byte_store.sv
`timescale 1ns/10ps
// ==========================================================================
// eight-byte image store with registered read data
// ==========================================================================
module dci_byte_store
   import dci_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       wr_en_i,
   input  wire logic [2:0] wr_idx_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic [2:0] rd_idx_i,
   output logic      [7:0] rd_data_o
);

   logic [7:0] mem_q [IMAGE_BYTES];

   // byte array, cleared at reset
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         for (int i = 0; i < IMAGE_BYTES; i++)
         begin
            mem_q[i] <= BYTE_RST;
         end
      end
      else if (wr_en_i)
      begin
         mem_q[wr_idx_i] <= wr_data_i;
      end
   end

   // read data comes from a register one cycle after the address
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rd_data_o <= BYTE_RST;
      end
      else
      begin
         rd_data_o <= mem_q[rd_idx_i];
      end
   end

endmodule : dci_byte_store

// file: design/dci_config_image.sv
`timescale 1ns/10ps
module dci_config_image
   import dci_pkg::*;
#(
   parameter int SETTLE_CYC = SETTLE_CYCLES
)
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [5:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        pll_lock_i,
   input  wire logic        vco_stable_i,
   input  wire logic        bit_error_i,
   input  wire logic        frame_start_i,
   input  wire logic        pix_valid_i,
   input  wire logic [23:0] pix_data_i,
   input  wire logic [2:0]  pix_ctrl_i,
   output logic      [23:0] pixel_data_bus_o,
   output logic      [2:0]  pixel_control_signals_o,
   output logic             pixel_clock_output_en_o,
   output logic             dedicated_up_en_o,
   output logic             embedded_up_en_o,
   output logic             fault_tolerant_o,
   output logic             device_reset_o
);

   // ========================================================================
   // decode helpers
   // ========================================================================
   // mask of the active pixel bits for a width code
   function automatic logic [23:0] width_mask(input logic [1:0] code);
      logic [23:0] m;
      m = 24'h00_0000;
      unique case (code)
         WIDTH_10: m = 24'h00_03FF;
         WIDTH_12: m = 24'h00_0FFF;
         WIDTH_18: m = 24'h03_FFFF;
         WIDTH_24: m = 24'hFF_FFFF;
      endcase
      return m;
   endfunction : width_mask

   // upstream enables {dedicated, embedded}; both requested means none
   function automatic logic [1:0] upstream_sel(input logic [7:0] b);
      logic [1:0] s;
      s = {b[BIT_DED_UP], b[BIT_EMB_UP]};
      if (&s)
      begin
         s = 2'h0;
      end
      return s;
   endfunction : upstream_sel

   // ========================================================================
   // pin synchronisers
   // ========================================================================
   logic [1:0] lock_sync_q;
   logic [1:0] vco_sync_q;
   logic       lock_prev_q;
   logic       lock_s;
   logic       vco_s;

   // two stages for lock and oscillator-stable pins
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         lock_sync_q <= 2'h0;
         vco_sync_q  <= 2'h0;
         lock_prev_q <= 1'b0;
      end
      else
      begin
         lock_sync_q <= {lock_sync_q[0], pll_lock_i};
         vco_sync_q  <= {vco_sync_q[0], vco_stable_i};
         lock_prev_q <= lock_sync_q[1];
      end
   end
   assign lock_s = lock_sync_q[1];
   assign vco_s  = vco_sync_q[1];

   // ========================================================================
   // avalon slave
   // ========================================================================
   dci_state_t  state_q;
   logic        ack_q;
   logic        req;
   logic [3:0]  bus_idx;
   logic        bus_ok;
   logic        bus_img;
   logic        wr_take;
   logic        apply_p;
   logic        sel_mem_q;
   logic [31:0] reg_rdata_q;
   logic [7:0]  mem_rdata;
   logic [31:0] status_w;
   logic        img_valid_q;
   logic        img_bad_q;
   logic        link_fault_q;
   logic [7:0]  act_q [1:4];

   assign req     = avs_read_i | avs_write_i;
   assign bus_idx = avs_address_i[5:2];
   assign bus_ok  = (avs_address_i[1:0] == 2'h0) && (bus_idx <= IDX_CONTROL);
   assign bus_img = bus_ok && (bus_idx <= IDX_END_MARKER);
   assign wr_take = avs_write_i && ack_q && bus_ok && avs_byteenable_i[0];
   assign apply_p = wr_take && (bus_idx == IDX_CONTROL) && avs_writedata_i[BIT_APPLY];
   assign avs_waitrequest_o = req & ~ack_q;
   assign avs_readdata_o    = sel_mem_q ? {24'h00_0000, mem_rdata} : reg_rdata_q;

   assign status_w = {26'h000_0000, img_bad_q, lock_s, link_fault_q, (state_q == ST_RUN),
                      (state_q == ST_SETTLE), img_valid_q};

   // second cycle of every access answers; stalled while the image loads
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ack_q       <= 1'b0;
         sel_mem_q   <= 1'b0;
         reg_rdata_q <= WORD_RST;
      end
      else
      begin
         ack_q     <= req && !ack_q && (state_q != ST_LOAD);
         sel_mem_q <= bus_img;
         if (bus_ok && bus_idx == IDX_STATUS)
         begin
            reg_rdata_q <= status_w;
         end
         else
         begin
            reg_rdata_q <= WORD_RST; // control and unmapped read zero
         end
      end
   end

   // ========================================================================
   // image store and loader
   // ========================================================================
   logic [3:0] ld_cnt_q;
   logic [7:0] stg_q [1:4];
   logic       start_ok_q;
   logic       ld_done;
   logic       end_ok;
   logic       img_ok;
   logic [2:0] rd_idx;
   logic [SETTLE_W-1:0] settle_cnt_q;

   assign rd_idx  = (state_q == ST_LOAD) ? ld_cnt_q[2:0] : bus_idx[2:0];
   assign ld_done = (state_q == ST_LOAD) && (ld_cnt_q == 4'h8);
   assign end_ok  = (mem_rdata == END_MARKER_VAL);
   assign img_ok  = start_ok_q && end_ok;

   dci_byte_store u_store (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .wr_en_i   (wr_take && bus_img),
      .wr_idx_i  (bus_idx[2:0]),
      .wr_data_i (avs_writedata_i[7:0]),
      .rd_idx_i  (rd_idx),
      .rd_data_o (mem_rdata)
   );

   // walk the eight bytes, staging option bytes and checking the start marker
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ld_cnt_q   <= 4'h0;
         start_ok_q <= 1'b0;
         for (int i = 1; i <= 4; i++)
         begin
            stg_q[i] <= BYTE_RST;
         end
      end
      else if (state_q != ST_LOAD)
      begin
         ld_cnt_q <= 4'h0;
      end
      else
      begin
         ld_cnt_q <= ld_cnt_q + 4'h1;
         if (ld_cnt_q == 4'h1)
         begin
            start_ok_q <= (mem_rdata == START_MARKER_VAL);
         end
         if (ld_cnt_q >= 4'h2 && ld_cnt_q <= 4'h5)
         begin
            stg_q[ld_cnt_q - 4'h1] <= mem_rdata;
         end
      end
   end

   // commit the staged options only from a valid image
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         img_valid_q <= 1'b0;
         img_bad_q   <= 1'b0;
         for (int i = 1; i <= 4; i++)
         begin
            act_q[i] <= BYTE_RST;
         end
      end
      else if (ld_done)
      begin
         img_valid_q <= img_ok;
         img_bad_q   <= !img_ok;
         if (img_ok)
         begin
            act_q <= stg_q;
         end
      end
   end

   // ========================================================================
   // controller: load, settle, run
   // ========================================================================
   logic pll_drop;
   assign pll_drop = lock_prev_q && !lock_s && !act_q[IDX_PLL_LOSS][BIT_PLL_NORESET];

   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_q        <= ST_IDLE;
         settle_cnt_q   <= '0;
         device_reset_o <= 1'b0;
      end
      else
      begin
         device_reset_o <= 1'b0;
         unique case (state_q)
            ST_IDLE:
            begin
               if (apply_p)
               begin
                  state_q <= ST_LOAD;
               end
            end
            ST_LOAD:
            begin
               settle_cnt_q <= '0;
               if (ld_done)
               begin
                  if (!img_ok)
                  begin
                     state_q <= ST_IDLE;
                  end
                  else if (stg_q[IDX_LINK_WAKE][BIT_WAIT_CFG])
                  begin
                     state_q <= ST_SETTLE;
                  end
                  else
                  begin
                     state_q <= ST_RUN;
                  end
               end
            end
            ST_SETTLE, ST_RUN:
            begin
               if (pll_drop)
               begin
                  device_reset_o <= 1'b1;
                  state_q        <= ST_LOAD;
               end
               else if (apply_p)
               begin
                  state_q <= ST_LOAD;
               end
               else if (state_q == ST_SETTLE)
               begin
                  settle_cnt_q <= settle_cnt_q + 1'b1;
                  if (settle_cnt_q == SETTLE_W'(SETTLE_CYC - 1))
                  begin
                     state_q <= ST_RUN;
                  end
               end
            end
         endcase
      end
   end

   // ========================================================================
   // link options and fault tracking
   // ========================================================================
   assign {dedicated_up_en_o, embedded_up_en_o} = upstream_sel(act_q[IDX_LINK_WAKE]);
   assign fault_tolerant_o = act_q[IDX_ALIGN_FAULT][BIT_FAULT_TOL];

   // an untolerated bit error while running is sticky until the next apply
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         link_fault_q <= 1'b0;
      end
      else if (bit_error_i && !fault_tolerant_o && state_q == ST_RUN)
      begin
         link_fault_q <= 1'b1;
      end
      else if (apply_p)
      begin
         link_fault_q <= 1'b0;
      end
   end

   // ========================================================================
   // pixel output path
   // ========================================================================
   logic       aligned_q;
   logic       even_q;
   logic       wake_ok;
   logic       data_on;
   logic [1:0] ctrl_mode;

   assign ctrl_mode = act_q[IDX_PIX_FORMAT][3:2];
   assign wake_ok   = act_q[IDX_LINK_WAKE][BIT_WAKE1] || vco_s;
   assign data_on   = (state_q == ST_RUN) && wake_ok &&
                      (aligned_q || !act_q[IDX_ALIGN_FAULT][BIT_ALIGN_DATA]);

   // frame alignment and even-pixel phase
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         aligned_q <= 1'b0;
         even_q    <= 1'b1;
      end
      else
      begin
         if (state_q != ST_RUN)
         begin
            aligned_q <= 1'b0;
         end
         else if (frame_start_i)
         begin
            aligned_q <= 1'b1;
         end
         if (frame_start_i)
         begin
            even_q <= 1'b1;
         end
         else if (pix_valid_i)
         begin
            even_q <= !even_q;
         end
      end
   end

   // registered pixel data, control and clock gate
   always_ff @(posedge sys_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pixel_data_bus_o        <= 24'h00_0000;
         pixel_control_signals_o <= 3'h0;
         pixel_clock_output_en_o <= 1'b0;
      end
      else
      begin
         pixel_clock_output_en_o <= (state_q == ST_RUN) && wake_ok &&
                                    (aligned_q || !act_q[IDX_ALIGN_FAULT][BIT_ALIGN_CLK]);
         if (!data_on)
         begin
            pixel_data_bus_o        <= 24'h00_0000;
            pixel_control_signals_o <= 3'h0;
         end
         else if (pix_valid_i)
         begin
            pixel_data_bus_o <= pix_data_i & width_mask(act_q[IDX_PIX_FORMAT][1:0]);
            if (ctrl_mode == CTRL_EVERY || (ctrl_mode == CTRL_EVEN && even_q))
            begin
               pixel_control_signals_o <= pix_ctrl_i;
            end
            else if (ctrl_mode == CTRL_NEVER || ctrl_mode == CTRL_UNUSED)
            begin
               pixel_control_signals_o <= 3'h0;
            end
         end
      end
   end

   // ========================================================================
   // checks
   // ========================================================================
   a_wake_hold_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (!act_q[IDX_LINK_WAKE][BIT_WAKE1] && !vco_s) |=> pixel_data_bus_o == 24'h00_0000)
      else $error("pixel data not held at zero before oscillator stable");
   a_upstream_sel: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      dedicated_up_en_o == (act_q[IDX_LINK_WAKE][BIT_DED_UP] && !act_q[IDX_LINK_WAKE][BIT_EMB_UP]))
      else $error("dedicated upstream enable wrong");
   a_upstream_both_off: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (act_q[IDX_LINK_WAKE][BIT_DED_UP] && act_q[IDX_LINK_WAKE][BIT_EMB_UP])
      |-> !(dedicated_up_en_o || embedded_up_en_o))
      else $error("upstream not disabled when both types requested");
   a_settle_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (state_q == ST_SETTLE && !pll_drop && !apply_p && settle_cnt_q < SETTLE_W'(SETTLE_CYC - 1))
      |=> state_q == ST_SETTLE)
      else $error("settle delay ended early");
   a_no_wait_run: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (ld_done && img_ok && !stg_q[IDX_LINK_WAKE][BIT_WAIT_CFG]) |=> state_q == ST_RUN)
      else $error("delay applied with wait bit clear");
   a_width_mask: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $stable(act_q[IDX_PIX_FORMAT]) |-> (pixel_data_bus_o & ~width_mask(act_q[IDX_PIX_FORMAT][1:0])) == 24'h0)
      else $error("pixel data wider than selected width");
   a_ctrl_never: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (ctrl_mode == CTRL_NEVER && pix_valid_i) |=> pixel_control_signals_o == 3'h0)
      else $error("control signals passed in never mode");
   a_align_data: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (act_q[IDX_ALIGN_FAULT][BIT_ALIGN_DATA] && !aligned_q) |=> pixel_data_bus_o == 24'h00_0000)
      else $error("pixel data before upper-left corner");
   a_align_clk: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (act_q[IDX_ALIGN_FAULT][BIT_ALIGN_CLK] && !aligned_q) |=> !pixel_clock_output_en_o)
      else $error("pixel clock before upper-left corner");
   a_fault_sticky: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (bit_error_i && !fault_tolerant_o && state_q == ST_RUN) |=> link_fault_q)
      else $error("untolerated bit error not flagged");
   a_pll_reset: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (pll_drop && (state_q == ST_RUN || state_q == ST_SETTLE)) |=> device_reset_o && state_q == ST_LOAD)
      else $error("pll loss did not reset");
   a_bad_image: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      (ld_done && !img_ok) |=> state_q == ST_IDLE && img_bad_q && $stable(act_q[IDX_PIX_FORMAT]))
      else $error("invalid image accepted");

endmodule : dci_config_image

// file: verification/dci_host_model.sv
`timescale 1ns/10ps
// ==========================================
// host model: avalon master loading the image
// ==========================================
module dci_host_model
(
   input  wire logic        sys_clk_i,
   output logic      [5:0]  avs_address_o,
   output logic             avs_read_o,
   output logic             avs_write_o,
   output logic      [31:0] avs_writedata_o,
   output logic      [3:0]  avs_byteenable_o,
   input  wire logic [31:0] avs_readdata_i,
   input  wire logic        avs_waitrequest_i
);
   // bus idle at time zero
   initial
   begin
      avs_address_o = 6'h00;
      avs_read_o = 1'b0;
      avs_write_o = 1'b0;
      avs_writedata_o = 32'h0000_0000;
      avs_byteenable_o = 4'hF;
   end
   // one transfer, held until waitrequest is seen low
   task automatic xfer(input logic rd, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
      @(posedge sys_clk_i);
      avs_read_o <= rd;
      avs_write_o <= !rd;
      avs_address_o <= a;
      avs_writedata_o <= {24'h00_0000, d};
      // no local limit: only the bench watchdog may end a stalled wait
      do
      begin
         @(posedge sys_clk_i);
      end
      while (avs_waitrequest_i !== 1'b0);
      q = avs_readdata_i;
      avs_read_o <= 1'b0;
      avs_write_o <= 1'b0;
   endtask : xfer
   // full image framed by markers (end marker 8'h98 instead of 8'h99 when bad), then apply
   task automatic load(input logic [7:0] b1, b2, b3, b4, input logic bad);
      logic [7:0]  img [8];
      logic [31:0] q;
      img = '{8'hBD, b1, b2, b3, b4, 8'h00, 8'h00, bad ? 8'h98 : 8'h99};
      for (int i = 0; i < 8; i++)
         xfer(1'b0, 6'(i * 4), img[i], q);
      xfer(1'b0, 6'h24, 8'h01, q);
   endtask : load
endmodule : dci_host_model

// file: verification/tb_dci_config_image.sv
`timescale 1ns/10ps
// ==========================================
// testbench for the configuration image loader
// ==========================================
module tb_dci_config_image;
   import dci_pkg::*;
   typedef struct packed {logic [7:0] b1, b2, b3; logic [2:0] up; logic [23:0] dat; logic [2:0] ctl;} dci_row_t;
   logic        sys_clk_i = 1'b0, rst_b_i = 1'b0, pll_lock_i = 1'b1, vco_stable_i = 1'b1;
   logic        frame_start_i = 1'b0, pix_valid_i = 1'b0, bit_error_i = 1'b0;
   logic [5:0]  adr;
   logic        rd, wr, wrq, clk_en, ded, emb, ft, dev_rst;
   logic [31:0] wd, rdat, q;
   logic [3:0]  be;
   logic [23:0] pdat;
   logic [2:0]  pctl;
   int          n_errors = 0, checked = 0, c;
   dci_row_t    rows [4] = '{
      '{8'h02, 8'h00, 8'h08, 3'b001, 24'h0003FF, 3'h0},
      '{8'h0A, 8'h05, 8'h00, 3'b100, 24'h000FFF, 3'h0},
      '{8'h12, 8'h0A, 8'h08, 3'b011, 24'h03FFFF, 3'h5},
      '{8'h1A, 8'h0F, 8'h02, 3'b000, 24'hFFFFFF, 3'h5}};
   dci_config_image #(.SETTLE_CYC(20)) i_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wrq), .pll_lock_i(pll_lock_i), .vco_stable_i(vco_stable_i), .bit_error_i(bit_error_i),
      .frame_start_i(frame_start_i), .pix_valid_i(pix_valid_i), .pix_data_i(24'hFFFFFF), .pix_ctrl_i(3'h5),
      .pixel_data_bus_o(pdat), .pixel_control_signals_o(pctl), .pixel_clock_output_en_o(clk_en),
      .dedicated_up_en_o(ded), .embedded_up_en_o(emb), .fault_tolerant_o(ft), .device_reset_o(dev_rst));
   dci_host_model i_host (.sys_clk_i(sys_clk_i), .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr),
      .avs_writedata_o(wd), .avs_byteenable_o(be), .avs_readdata_i(rdat), .avs_waitrequest_i(wrq));
   // 50 MHz clock
   always #10 sys_clk_i = ~sys_clk_i;
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // poll status until running
   task automatic wait_run();
      for (int i = 0; i < 40; i++)
      begin
         i_host.xfer(1'b1, 6'h20, 8'h00, q);
         if (q[ST_RUNNING] === 1'b1)
            return;
      end
      chk(q[ST_RUNNING], 1'b1);
   endtask : wait_run
   // one pixel after a frame start, outputs looked at once settled
   task automatic pixel();
      @(posedge sys_clk_i) frame_start_i <= 1'b1;
      @(posedge sys_clk_i) frame_start_i <= 1'b0;
      pix_valid_i <= 1'b1;
      @(posedge sys_clk_i) pix_valid_i <= 1'b0;
      @(negedge sys_clk_i);
   endtask : pixel
   // count reset pulses after loss of lock
   task automatic lose_lock(output int n);
      n = 0;
      @(posedge sys_clk_i) pll_lock_i <= 1'b0;
      repeat (10) @(negedge sys_clk_i) n += (dev_rst === 1'b1);
      @(posedge sys_clk_i) pll_lock_i <= 1'b1;
   endtask : lose_lock
   // watchdog
   initial
   begin
      repeat (20000) @(posedge sys_clk_i);
      n_errors++;
      wrap_up();
   end
   // main sequence
   initial
   begin
      repeat (20) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      i_host.xfer(1'b1, 6'h04, 8'h00, q);
      chk(q, 32'h0);
      chk(pdat, 24'h0);
      foreach (rows[i])
      begin
         i_host.load(rows[i].b1, rows[i].b2, rows[i].b3, 8'h00, 1'b0);
         wait_run();
         pixel();
         chk({ded, emb, ft}, rows[i].up);
         chk(pdat, rows[i].dat);
         chk(pctl, rows[i].ctl);
      end
      // untolerated bit error in run sets the sticky fault, apply clears it
      @(posedge sys_clk_i) bit_error_i <= 1'b1;
      @(posedge sys_clk_i) bit_error_i <= 1'b0;
      i_host.xfer(1'b1, 6'h20, 8'h00, q);
      chk(q[ST_LINK_FAULT], 1'b1);
      i_host.load(8'h00, 8'h00, 8'h04, 8'h00, 1'b0);
      wait_run();
      chk(q[ST_LINK_FAULT], 1'b0);
      // clock gated until the first frame start while the oscillator is stable
      repeat (3) @(negedge sys_clk_i);
      chk(clk_en, 1'b0);
      @(posedge sys_clk_i) vco_stable_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      pixel();
      chk(pdat, 24'h0);
      chk(clk_en, 1'b0);
      @(posedge sys_clk_i) vco_stable_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      pixel();
      chk(pdat, 24'h0003FF);
      chk(clk_en, 1'b1);
      lose_lock(c);
      chk(c, 1);
      wait_run();
      i_host.load(8'h82, 8'h00, 8'h00, 8'h01, 1'b0);
      i_host.xfer(1'b1, 6'h20, 8'h00, q);
      chk(q[ST_SETTLING], 1'b1);
      repeat (12) @(posedge sys_clk_i);
      i_host.xfer(1'b1, 6'h20, 8'h00, q);
      chk(q[ST_RUNNING], 1'b0);
      wait_run();
      lose_lock(c);
      chk(c, 0);
      i_host.load(8'h0A, 8'h00, 8'h00, 8'h00, 1'b1);
      i_host.xfer(1'b1, 6'h20, 8'h00, q);
      chk({q[ST_IMAGE_BAD], q[ST_IMAGE_VALID]}, 2'b10);
      chk(ded, 1'b0);
      i_host.xfer(1'b1, 6'h3C, 8'h00, q);
      chk(q, 32'h0);
      wrap_up();
   end
endmodule : tb_dci_config_image
